// File: pgm_board_model.sv
`timescale 1ns/1ps
// board side of the six pins, driving only where the block has let go
module pgm_board_model (
  input  wire logic [5:0] pin_o,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] ext_level,
  output logic      [5:0] pin_i
);
  // wire level from both drivers; the block's enable wins the pin
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_level);
endmodule

// File: pgm_pin_mux.sv
`timescale 1ns/1ps
// per-pin function selection between port and serial channels
module pgm_pin_mux (
  input  wire logic [5:0] pin_direction_bit,
  input  wire logic [5:0] port_data,
  input  wire logic [1:0] serial_clock_enable_low,
  input  wire logic [1:0] serial_clock_enable_high,
  input  wire logic [1:0] sync_mode,
  input  wire logic [1:0] receive_enable,
  input  wire logic [1:0] transmit_enable,
  input  wire logic [1:0] serial_clock_out,
  input  wire logic [1:0] transmit_data,
  output logic      [5:0] pin_o,
  output logic      [5:0] pin_oe,
  output logic      [5:0] port_owned
);
  always_comb begin
    port_owned = 6'h3f;
    pin_oe     = pin_direction_bit;
    pin_o      = port_data;
    // serial clocks: pin 4 channel 0, pin 5 channel 1
    for (int c = 0; c < 2; c++) begin
      if (serial_clock_enable_high[c]) begin
        port_owned[4+c] = 1'b0;
        pin_oe[4+c]     = 1'b0;
      end else if (sync_mode[c] || serial_clock_enable_low[c]) begin
        port_owned[4+c] = 1'b0;
        pin_oe[4+c]     = 1'b1;
        pin_o[4+c]      = serial_clock_out[c];
      end
      // receive: pin 2 channel 0, pin 3 channel 1
      if (receive_enable[c]) begin
        port_owned[2+c] = 1'b0;
        pin_oe[2+c]     = 1'b0;
      end
      // transmit: pin 0 channel 0, pin 1 channel 1
      if (transmit_enable[c]) begin
        port_owned[c] = 1'b0;
        pin_oe[c]     = 1'b1;
        pin_o[c]      = transmit_data[c];
      end
    end
  end
endmodule

// File: pgm_pkg.sv
package pgm_pkg;
  // register indices; the bus byte address is four times the index, since ffd2 is not word aligned
  localparam logic [15:0] dir_addr   = 16'hffd0;
  localparam logic [15:0] data_addr  = 16'hffd2;
  localparam logic [15:0] ctrl_addr  = 16'hffd4;
  localparam logic [15:0] stat_addr  = 16'hffd8;
  // reset values, reserved-bit mask, read-back value and pin count
  localparam logic [7:0]  dir_reset  = 8'hc0;
  localparam logic [7:0]  data_reset = 8'hc0;
  localparam logic [7:0]  rsvd_mask  = 8'hc0;
  localparam logic [7:0]  read_ones  = 8'hff;
  localparam int          pin_count  = 6;
  // serial control bit positions, one byte per channel in the control register
  localparam int ctl_clk_low   = 0;
  localparam int ctl_clk_high  = 1;
  localparam int ctl_sync_mode = 2;
  localparam int ctl_rx_enable = 3;
  localparam int ctl_tx_enable = 4;
  localparam int ctl_ch1_base  = 8;
  // axi response codes
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// File: pgm_port9.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module pgm_port9 #(
  parameter int addr_width = 18
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  hw_standby,
  input  wire logic                  sw_standby,
  // axi4-lite slave
  input  wire logic [addr_width-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic      [1:0]            s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [addr_width-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // pins
  input  wire logic [5:0]            pin_i,
  output logic      [5:0]            pin_o,
  output logic      [5:0]            pin_oe,
  // serial channels, bit 0 channel 0, bit 1 channel 1
  input  wire logic [1:0]            serial_clock_out,
  input  wire logic [1:0]            transmit_data,
  output logic      [1:0]            serial_clock_in,
  output logic      [1:0]            receive_data,
  // external interrupt inputs, bit 0 four, bit 1 five
  output logic      [1:0]            external_interrupt
);
  logic [7:0]            pin_direction_register;
  logic [7:0]            pin_data_register;
  logic [15:0]           serial_ctrl_reg;
  logic [5:0]            pin_sync;
  logic [5:0]            port_owned;
  logic                  aw_held_reg;
  logic                  w_held_reg;
  logic [addr_width-1:0] awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  do_write;
  logic [7:0]            data_view;
  logic [31:0]           read_word;
  logic                  read_hit;
  logic                  write_hit;
  logic [addr_width-3:0] aw_index;
  logic [addr_width-3:0] ar_index;

  // one register per 32-bit word, so the word index is the register index
  assign aw_index = awaddr_reg[addr_width-1:2];
  assign ar_index = s_axi_araddr[addr_width-1:2];

  // pin levels come from outside the clock domain
  pgm_sync #(
    .width(6)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .async_in(pin_i),
    .sync_out(pin_sync)
  );

  // pin ownership and drive selection
  pgm_pin_mux u_mux (
    .pin_direction_bit       (pin_direction_register[5:0]),
    .port_data               (pin_data_register[5:0]),
    .serial_clock_enable_low ({serial_ctrl_reg[pgm_pkg::ctl_ch1_base + pgm_pkg::ctl_clk_low],
                               serial_ctrl_reg[pgm_pkg::ctl_clk_low]}),
    .serial_clock_enable_high({serial_ctrl_reg[pgm_pkg::ctl_ch1_base + pgm_pkg::ctl_clk_high],
                               serial_ctrl_reg[pgm_pkg::ctl_clk_high]}),
    .sync_mode               ({serial_ctrl_reg[pgm_pkg::ctl_ch1_base + pgm_pkg::ctl_sync_mode],
                               serial_ctrl_reg[pgm_pkg::ctl_sync_mode]}),
    .receive_enable          ({serial_ctrl_reg[pgm_pkg::ctl_ch1_base + pgm_pkg::ctl_rx_enable],
                               serial_ctrl_reg[pgm_pkg::ctl_rx_enable]}),
    .transmit_enable         ({serial_ctrl_reg[pgm_pkg::ctl_ch1_base + pgm_pkg::ctl_tx_enable],
                               serial_ctrl_reg[pgm_pkg::ctl_tx_enable]}),
    .serial_clock_out        (serial_clock_out),
    .transmit_data           (transmit_data),
    .pin_o                   (pin_o),
    .pin_oe                  (pin_oe),
    .port_owned              (port_owned)
  );

  // peripheral inputs see the synchronised pins directly
  assign serial_clock_in    = pin_sync[5:4];
  assign receive_data       = pin_sync[3:2];
  assign external_interrupt = pin_sync[5:4];

  // write channel capture: address and data in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // decode on the word index, which keeps ffd0 and ffd2 apart
  always_comb begin
    write_hit = 1'b0;
    case (aw_index)
      pgm_pkg::dir_addr,
      pgm_pkg::data_addr,
      pgm_pkg::ctrl_addr,
      pgm_pkg::stat_addr: write_hit = 1'b1;
      default:            write_hit = 1'b0;
    endcase
  end

  // write response, one per completed write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pgm_pkg::resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= write_hit ? pgm_pkg::resp_okay : pgm_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // direction register; hardware standby acts like reset, software standby just holds
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      pin_direction_register <= pgm_pkg::dir_reset;
    end else if (do_write && !sw_standby && wstrb_reg[0]
                 && aw_index == pgm_pkg::dir_addr) begin
      pin_direction_register <= pgm_pkg::rsvd_mask | wdata_reg[7:0];
    end
  end

  // data register keeps the upper bits at one whatever is written
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      pin_data_register <= pgm_pkg::data_reset;
    end else if (do_write && !sw_standby && wstrb_reg[0]
                 && aw_index == pgm_pkg::data_addr) begin
      pin_data_register <= pgm_pkg::rsvd_mask | wdata_reg[7:0];
    end
  end

  // serial mode and enable bits stand in for the channel control registers
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      serial_ctrl_reg <= 16'h0000;
    end else if (do_write && !sw_standby && aw_index == pgm_pkg::ctrl_addr) begin
      if (wstrb_reg[0]) begin
        serial_ctrl_reg[7:0] <= wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
        serial_ctrl_reg[15:8] <= wdata_reg[15:8];
      end
    end
  end

  // per-pin read view: stored bit on outputs, live level on inputs
  always_comb begin
    data_view = pgm_pkg::rsvd_mask;
    for (int i = 0; i < pgm_pkg::pin_count; i++) begin
      data_view[i] = pin_direction_register[i] ? pin_data_register[i] : pin_sync[i];
    end
  end

  // read mux; the direction register never shows its contents
  always_comb begin
    read_word = 32'h0000_0000;
    read_hit  = 1'b1;
    case (ar_index)
      pgm_pkg::dir_addr:  read_word[7:0]  = pgm_pkg::read_ones;
      pgm_pkg::data_addr: read_word[7:0]  = data_view;
      pgm_pkg::ctrl_addr: read_word[15:0] = serial_ctrl_reg;
      pgm_pkg::stat_addr: read_word       = {20'h00000, port_owned, pin_oe};
      default:            read_hit        = 1'b0;
    endcase
  end

  // read channel: one read at a time, answer the cycle after the address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= pgm_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_word;
      s_axi_rresp  <= read_hit ? pgm_pkg::resp_okay : pgm_pkg::resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: pgm_port9_monitor.sv
`timescale 1ns/1ps
// read, standby and input sync checks seen from the block ports
module pgm_port9_monitor #(
  parameter int addr_width = 18
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  hw_standby,
  input wire logic                  sw_standby,
  input wire logic [addr_width-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [5:0]            pin_i,
  input wire logic [5:0]            pin_oe,
  input wire logic [1:0]            receive_data,
  input wire logic [1:0]            external_interrupt
);
  localparam logic [addr_width-1:0] dir_b  = {pgm_pkg::dir_addr, 2'h0};
  localparam logic [addr_width-1:0] data_b = {pgm_pkg::data_addr, 2'h0};
  logic [addr_width-1:0] last_ar;
  logic [5:0]            pin_d1, pin_d2;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read target and pin history, so each answer is judged against its cause
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) last_ar <= s_axi_araddr;
    pin_d1 <= pin_i;
    pin_d2 <= pin_d1;
  end
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_rd_resp_next: assert property (s_ar_taken |=> s_axi_rvalid) else $error("read answer late");
  a_rd_one_beat: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read twice");
  a_dir_all_ones: assert property (s_axi_rvalid && last_ar == dir_b |-> s_axi_rdata[7:0] == 8'hff) else $error("dir");
  a_data_top_ones: assert property (s_axi_rvalid && last_ar == data_b |-> s_axi_rdata[7:6] == 2'h3) else $error("top");
  a_reset_undriven: assert property ($rose(aresetn) |-> pin_oe == 6'h00) else $error("driven after reset");
  a_hwsb_undriven: assert property (hw_standby |=> pin_oe == 6'h00) else $error("driven in standby");
  a_swsb_keeps_oe: assert property (sw_standby && !hw_standby |=> $stable(pin_oe)) else $error("oe moved");
  a_sync_two_late: assert property ($past(aresetn, 2) |-> {external_interrupt, receive_data} == pin_d2[5:2]) else $error("sync");
endmodule
bind pgm_port9 pgm_port9_monitor #(.addr_width(addr_width)) mon_u (.aclk, .aresetn, .hw_standby, .sw_standby,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_i, .pin_oe,
  .receive_data, .external_interrupt);

// File: pgm_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for the pin inputs
module pgm_sync #(
  parameter int width = 6
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [width-1:0] async_in,
  output logic      [width-1:0] sync_out
);
  logic [width-1:0] meta_reg;

  // first stage is read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// File: port9_gpio_serial_pin_mux_tb_top.sv
`timescale 1ns/1ps
// directed register and pin sharing checks through the bus
module port9_gpio_serial_pin_mux_tb_top;
  localparam logic [15:0] di = pgm_pkg::dir_addr;
  localparam logic [15:0] da = pgm_pkg::data_addr;
  logic        aclk = 1'h0, aresetn = 1'h0, hw_standby = 1'h0, sw_standby = 1'h0;
  logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic [1:0]  serial_clock_out = 2'h1, transmit_data = 2'h2, s_axi_bresp, s_axi_rresp, rd_r;
  logic [1:0]  serial_clock_in, receive_data, external_interrupt, wr_r;
  logic [5:0]  ext_level = 6'h00, pin_i, pin_o, pin_oe;
  int          err_count = 0, check_count = 0;
  // direction, control, expected enables and expected driven levels
  logic [5:0]  t_dir [3] = '{6'h3f, 6'h00, 6'h3f};
  logic [15:0] t_ctl [3] = '{16'h1c1a, 16'h0101, 16'h0606};
  logic [5:0]  t_oe [3] = '{6'h23, 6'h30, 6'h0f};
  logic [5:0]  t_po [3] = '{6'h02, 6'h10, 6'h05};
  pgm_port9 #(.addr_width(18)) dut_u (.aclk, .aresetn, .hw_standby, .sw_standby, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pin_i, .pin_o, .pin_oe, .serial_clock_out, .transmit_data, .serial_clock_in, .receive_data,
    .external_interrupt);
  pgm_board_model board_u (.pin_o, .pin_oe, .ext_level, .pin_i);
  // 100 MHz clock
  initial forever #5 aclk = ~aclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge aclk);
    wr_r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [7:0] e);
    rd(idx, rd_d, rd_r);
    chk("rdata", e, rd_d[7:0]);
    chk("rresp", pgm_pkg::resp_okay, rd_r);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rdc(di, 8'hff);
    rdc(da, 8'hc0);
    chk("pin_oe", 6'h00, pin_oe);
    wr(di, 32'h0000_00ff);
    chk("pin_oe", 6'h3f, pin_oe);
    wr(da, 32'h0000_0015);
    chk("bresp", pgm_pkg::resp_okay, wr_r);
    rdc(da, 8'hd5);
    chk("pin_o", 6'h15, pin_o);
    wr(di, 32'h0000_000f);
    ext_level <= 6'h2a;
    repeat (3) @(posedge aclk);
    rdc(da, 8'he5);
    // writes in software standby must leave everything as it was
    sw_standby <= 1'h1;
    wr(di, 32'h0000_0000);
    wr(da, 32'h0000_0000);
    chk("pin_oe", 6'h0f, pin_oe);
    rdc(da, 8'he5);
    sw_standby <= 1'h0;
    ext_level <= 6'h1a;
    for (int i = 0; i < 3; i++) begin
      wr(di, {26'h0, t_dir[i]});
      wr(pgm_pkg::ctrl_addr, {16'h0, t_ctl[i]});
      repeat (3) @(posedge aclk);
      chk("pin_oe", t_oe[i], pin_oe);
      chk("pin_o", t_po[i], pin_o & t_oe[i]);
    end
    chk("inputs", 6'h15, {receive_data, serial_clock_in, external_interrupt});
    hw_standby <= 1'h1;
    @(posedge aclk);
    hw_standby <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("pin_oe", 6'h00, pin_oe);
    rdc(da, 8'hda);
    rd(16'h0010, rd_d, rd_r);
    chk("rresp", pgm_pkg::resp_slverr, rd_r);
    wr(16'h0010, 32'h0000_0000);
    chk("bresp", pgm_pkg::resp_slverr, wr_r);
    end_of_test();
  end
  // the run needs about a hundred cycles; the limit leaves room for slow answers
  initial begin
    #50000;
    err_count++;
    end_of_test();
  end
endmodule
